// *** core/fcg_defines.svh ***
// Register indices, reset values, masks and codes of the floppy config block.
`ifndef FCG_DEFINES_SVH
`define FCG_DEFINES_SVH

`define FCG_IDX_MODE  8'hf0
`define FCG_IDX_OPT   8'hf1
`define FCG_IDX_TYPE  8'hf2
`define FCG_IDX_RSVD  8'hf3
`define FCG_IDX_DRV0  8'hf4
`define FCG_IDX_DRV1  8'hf5
`define FCG_IDX_CTRL  8'h30
`define FCG_IDX_STAT  8'h31
`define FCG_ADDR(i)   ({2'h0, (i), 2'h0})

`define FCG_RST_MODE  8'h0e
`define FCG_RST_OPT   8'h00
`define FCG_RST_TYPE  8'hff
`define FCG_RST_DRV   8'h00

`define FCG_MASK_MODE 8'hdf
`define FCG_MASK_OPT  8'hfc
`define FCG_MASK_TYPE 8'hff
`define FCG_MASK_DRV  8'h5b

`define FCG_CTRL_ACT  0
`define FCG_CTRL_PWR  1

`define FCG_DENS_HI   2'h2
`define FCG_DENS_LO   2'h3

`define FCG_ECR_FIFO  3'h2
`define FCG_ECR_ECP   3'h3
`define FCG_ECR_TEST  3'h6

`define FCG_NSYNC     3

`endif

// *** core/fcg_pkg.sv ***
// Types shared by the floppy configuration block and its users.
package fcg_pkg;

  typedef enum logic [1:0] {
    fcg_if_legacy_b = 2'h0,
    fcg_if_legacy_a = 2'h1,
    fcg_if_rsvd     = 2'h2,
    fcg_if_at       = 2'h3
  } fcg_if_t;

  typedef struct packed {
    logic    tristate;
    logic    push_pull;
    logic    rsvd;
    logic    swap;
    fcg_if_t if_mode;
    logic    non_burst;
    logic    enh_mode;
  } fcg_mode_t;

  typedef struct packed {
    logic [1:0] boot;
    logic       mid1_inv;
    logic       mid0_inv;
    logic [1:0] density;
    logic [1:0] rsvd;
  } fcg_opt_t;

  typedef struct packed {
    logic       z7;
    logic       precomp_off;
    logic       z5;
    logic [1:0] rate_table_bits;
    logic       z2;
    logic [1:0] drive_kind_bits;
  } fcg_drv_t;

  typedef struct packed {
    logic o;
    logic oe;
  } fcg_pin_t;

  typedef enum logic [3:0] {
    fcg_rid_mode,
    fcg_rid_opt,
    fcg_rid_type,
    fcg_rid_rsvd,
    fcg_rid_drv0,
    fcg_rid_drv1,
    fcg_rid_ctrl,
    fcg_rid_stat,
    fcg_rid_none
  } fcg_rid_t;

endpackage

// *** core/fcg_core.sv ***
// Floppy configuration registers with interrupt and DMA pin gating.
`timescale 1ns/100ps
`include "fcg_defines.svh"
// Behaviour
// - DMA gate low floats floppy irq and acknowledge.
// - Floppy off or powered down floats its irq and acknowledge pins.
// - UART gate bit low floats that interrupt.
// - Standard parallel modes: irq enable gates interrupt.
// - Extended mode: DMA enable gates request; table irq.
// - Local gating adds to activate and address checks.
// - Game port and aux decode drive nothing.
// - Registers reset only on hard reset.
// - Mode bit 0 selects enhanced floppy mode.
// - Mode bit 1 selects non-burst DMA, default.
// - Mode bit 4 swaps drive and motor selects.
// - Mode bit 6 selects push-pull over open-drain.
// - Mode bit 7 floats outputs; parallel path untouched.
// - Option bits 3:2 force or pass density.
// - Option bits 4,5 invert media id inputs.
// - Option bits 7:6 name the boot drive.
// - Drive type register, two bits each, resets ones.
// - Index after drive type reads zero always.
// - Drive 0 settings: kind, rate table, zeros.
// - Settings bit 6 disables write precompensation.
// - Drive 1 settings mirror drive 0 layout.
// - Activate and power bits are one linked bit.
module fcg_core (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output wire logic [31:0]             prdata,
  output wire logic                    pready,
  output wire logic                    pslverr,
  input  wire logic                    floppy_dma_gate,
  input  wire logic                    fdc_base_ok,
  input  wire logic                    fdc_pwr_down,
  input  wire logic                    fdc_irq_req,
  input  wire logic                    fdc_dack_req,
  input  wire logic                    fdc_drq_pin,
  output wire logic                    fdc_drq_seen,
  input  wire logic [2:0]              dev_on,
  input  wire logic [1:0]              uart_irq_gate,
  input  wire logic [1:0]              uart_irq_req,
  input  wire logic                    ecp_on,
  input  wire logic [2:0]              ecr_mode,
  input  wire logic                    port_irq_enable,
  input  wire logic                    ecp_dma_enable,
  input  wire logic                    par_irq_req,
  input  wire logic                    par_dreq_req,
  input  wire logic [1:0]              drv_sel_req,
  input  wire logic [1:0]              mot_req,
  input  wire logic                    dens_req,
  input  wire logic [1:0]              media_id_pin,
  output wire fcg_pkg::fcg_pin_t       fdc_irq,
  output wire fcg_pkg::fcg_pin_t       fdc_dack,
  output wire fcg_pkg::fcg_pin_t [1:0] uart_irq,
  output wire fcg_pkg::fcg_pin_t       par_irq,
  output wire fcg_pkg::fcg_pin_t       parallel_dma_request,
  output wire fcg_pkg::fcg_pin_t [1:0] drv_sel,
  output wire fcg_pkg::fcg_pin_t [1:0] mot,
  output wire logic [1:0]              drv_sel_pp,
  output wire logic [1:0]              mot_pp,
  output wire logic                    dens_o,
  output wire logic [1:0]              media_id,
  output wire logic                    boot_valid,
  output wire logic                    boot_drive,
  output wire fcg_pkg::fcg_mode_t      mode_cfg,
  output wire fcg_pkg::fcg_opt_t       opt_cfg,
  output wire logic [7:0]              drive_type,
  output wire fcg_pkg::fcg_drv_t       drv0_cfg,
  output wire fcg_pkg::fcg_drv_t       drv1_cfg,
  output wire logic                    fdc_active
);

  typedef struct packed {
    fcg_pkg::fcg_mode_t      mode;
    fcg_pkg::fcg_opt_t       opt;
    logic [7:0]              dtype;
    fcg_pkg::fcg_drv_t       drv0;
    fcg_pkg::fcg_drv_t       drv1;
    logic                    act;
    logic [2:0]              s1;
    logic [2:0]              s2;
    logic [2:0]              s3;
    logic [2:0]              pin_q;
    fcg_pkg::fcg_pin_t       fdc_irq;
    fcg_pkg::fcg_pin_t       fdc_dack;
    logic                    drq_seen;
    fcg_pkg::fcg_pin_t [1:0] uart_irq;
    fcg_pkg::fcg_pin_t       par_irq;
    fcg_pkg::fcg_pin_t       par_dreq;
    fcg_pkg::fcg_pin_t [1:0] drv_sel;
    fcg_pkg::fcg_pin_t [1:0] mot;
    logic [1:0]              sel_pp;
    logic [1:0]              mot_pp;
    logic                    dens;
    logic [1:0]              media;
    logic                    boot_valid;
    logic                    boot_drive;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
  } fcg_st_t;

  fcg_st_t             st_ff;
  fcg_st_t             nxt_st;
  fcg_pkg::fcg_rid_t   rid;
  logic [7:0]          rdv;
  logic [7:0]          wbyte;
  logic                wr_done;
  logic                fdc_en;
  logic                fdc_dma;
  logic                par_irq_en;
  logic [1:0]          sel_v;
  logic [1:0]          mot_v;
  logic [1:0]          sel_rev;

  function automatic fcg_pkg::fcg_rid_t reg_sel(input logic [11:0] a);
    unique case (a)
      `FCG_ADDR(`FCG_IDX_MODE): reg_sel = fcg_pkg::fcg_rid_mode;
      `FCG_ADDR(`FCG_IDX_OPT):  reg_sel = fcg_pkg::fcg_rid_opt;
      `FCG_ADDR(`FCG_IDX_TYPE): reg_sel = fcg_pkg::fcg_rid_type;
      `FCG_ADDR(`FCG_IDX_RSVD): reg_sel = fcg_pkg::fcg_rid_rsvd;
      `FCG_ADDR(`FCG_IDX_DRV0): reg_sel = fcg_pkg::fcg_rid_drv0;
      `FCG_ADDR(`FCG_IDX_DRV1): reg_sel = fcg_pkg::fcg_rid_drv1;
      `FCG_ADDR(`FCG_IDX_CTRL): reg_sel = fcg_pkg::fcg_rid_ctrl;
      `FCG_ADDR(`FCG_IDX_STAT): reg_sel = fcg_pkg::fcg_rid_stat;
      default:                  reg_sel = fcg_pkg::fcg_rid_none;
    endcase
  endfunction

  // The value is forced low when floated so a stale level never leaks.
  function automatic fcg_pkg::fcg_pin_t pin_gate(input logic en,
                                                 input logic v);
    pin_gate.o  = v & en;
    pin_gate.oe = en;
  endfunction

  // Open-drain only pulls low, so a high level is left to the pull-up.
  function automatic fcg_pkg::fcg_pin_t drv_pin(
    input fcg_pkg::fcg_mode_t m,
    input logic               v);
    drv_pin.o  = v;
    drv_pin.oe = ~m.tristate & (m.push_pull | ~v);
  endfunction

  assign wbyte   = pwdata[7:0];
  assign wr_done = psel & penable & st_ff.pready & pwrite;
  assign sel_rev = {drv_sel_req[0], drv_sel_req[1]};

  always_comb begin
    nxt_st = st_ff;
    rid    = reg_sel(paddr);

    // Three-stage synchroniser; a level counts once stages two and three
    // agree, which filters a single-cycle glitch on the pins.
    nxt_st.s1 = {fdc_drq_pin, media_id_pin};
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < `FCG_NSYNC; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.pin_q[i] = st_ff.s3[i];
      end
    end

    unique case (rid)
      fcg_pkg::fcg_rid_mode: rdv = st_ff.mode;
      fcg_pkg::fcg_rid_opt:  rdv = st_ff.opt;
      fcg_pkg::fcg_rid_type: rdv = st_ff.dtype;
      fcg_pkg::fcg_rid_drv0: rdv = st_ff.drv0;
      fcg_pkg::fcg_rid_drv1: rdv = st_ff.drv1;
      fcg_pkg::fcg_rid_ctrl: rdv = {6'h0, st_ff.act, st_ff.act};
      fcg_pkg::fcg_rid_stat: rdv = {2'h0, st_ff.par_dreq.oe,
                                    st_ff.par_irq.oe,
                                    st_ff.uart_irq[1].oe,
                                    st_ff.uart_irq[0].oe,
                                    st_ff.fdc_dack.oe,
                                    st_ff.fdc_irq.oe};
      default:               rdv = 8'h00;
    endcase

    // Zero-wait slave: pready rises the cycle after setup, data with it.
    nxt_st.pready  = psel & ~penable & ~st_ff.pready;
    nxt_st.prdata  = 32'h0;
    nxt_st.pslverr = 1'b0;
    if (psel & ~penable) begin
      nxt_st.prdata  = {24'h0, rdv};
      nxt_st.pslverr = (rid == fcg_pkg::fcg_rid_none);
    end

    // Reserved positions are masked so they always read back zero.
    if (wr_done) begin
      unique case (rid)
        fcg_pkg::fcg_rid_mode:
          nxt_st.mode = wbyte & `FCG_MASK_MODE;
        fcg_pkg::fcg_rid_opt:
          nxt_st.opt = wbyte & `FCG_MASK_OPT;
        fcg_pkg::fcg_rid_type:
          nxt_st.dtype = wbyte & `FCG_MASK_TYPE;
        fcg_pkg::fcg_rid_drv0:
          nxt_st.drv0 = wbyte & `FCG_MASK_DRV;
        fcg_pkg::fcg_rid_drv1:
          nxt_st.drv1 = wbyte & `FCG_MASK_DRV;
        fcg_pkg::fcg_rid_ctrl:
          nxt_st.act = wbyte[`FCG_CTRL_ACT] | wbyte[`FCG_CTRL_PWR];
        default: ;
      endcase
    end

    // Floppy gating stacks the local DMA gate on the device enables.
    fdc_en  = st_ff.act & fdc_base_ok & ~fdc_pwr_down;
    fdc_dma = fdc_en & floppy_dma_gate;
    nxt_st.fdc_irq  = pin_gate(fdc_dma, fdc_irq_req);
    nxt_st.fdc_dack = pin_gate(fdc_dma, fdc_dack_req);
    nxt_st.drq_seen = fdc_dma & st_ff.pin_q[2];

    // Only the floppy, UART and parallel sources feed request pins.
    for (int i = 0; i < 2; i++) begin
      nxt_st.uart_irq[i] = pin_gate(dev_on[i] & uart_irq_gate[i],
                                    uart_irq_req[i]);
    end

    par_irq_en = port_irq_enable;
    if (ecp_on && (ecr_mode == `FCG_ECR_FIFO ||
                   ecr_mode == `FCG_ECR_ECP ||
                   ecr_mode == `FCG_ECR_TEST)) begin
      par_irq_en = 1'b1;
    end
    nxt_st.par_irq  = pin_gate(dev_on[2] & par_irq_en,
                               par_irq_req);
    nxt_st.par_dreq = pin_gate(dev_on[2] & ecp_on & ecp_dma_enable,
                               par_dreq_req);

    sel_v = st_ff.mode.swap ? sel_rev : drv_sel_req;
    mot_v = st_ff.mode.swap ? {mot_req[0], mot_req[1]} : mot_req;
    nxt_st.sel_pp = sel_v;
    nxt_st.mot_pp = mot_v;
    for (int i = 0; i < 2; i++) begin
      nxt_st.drv_sel[i] = drv_pin(st_ff.mode, sel_v[i]);
      nxt_st.mot[i]     = drv_pin(st_ff.mode, mot_v[i]);
    end

    if (st_ff.opt.density == `FCG_DENS_HI) begin
      nxt_st.dens = 1'b1;
    end else if (st_ff.opt.density == `FCG_DENS_LO) begin
      nxt_st.dens = 1'b0;
    end else begin
      nxt_st.dens = dens_req;
    end

    nxt_st.media = st_ff.pin_q[1:0] ^
                   {st_ff.opt.mid1_inv, st_ff.opt.mid0_inv};
    nxt_st.boot_valid = ~st_ff.opt.boot[1];
    nxt_st.boot_drive = st_ff.opt.boot[0];
  end

  // Only the hard reset line reaches these flops; soft resets of the
  // floppy core never touch the configuration.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff      <= '0;
      st_ff.mode <= `FCG_RST_MODE;
      st_ff.opt  <= `FCG_RST_OPT;
      st_ff.dtype <= `FCG_RST_TYPE;
      st_ff.drv0 <= `FCG_RST_DRV;
      st_ff.drv1 <= `FCG_RST_DRV;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata               = st_ff.prdata;
  assign pready               = st_ff.pready;
  assign pslverr              = st_ff.pslverr;
  assign fdc_drq_seen         = st_ff.drq_seen;
  assign fdc_irq              = st_ff.fdc_irq;
  assign fdc_dack             = st_ff.fdc_dack;
  assign uart_irq             = st_ff.uart_irq;
  assign par_irq              = st_ff.par_irq;
  assign parallel_dma_request = st_ff.par_dreq;
  assign drv_sel              = st_ff.drv_sel;
  assign mot                  = st_ff.mot;
  assign drv_sel_pp           = st_ff.sel_pp;
  assign mot_pp               = st_ff.mot_pp;
  assign dens_o               = st_ff.dens;
  assign media_id             = st_ff.media;
  assign boot_valid           = st_ff.boot_valid;
  assign boot_drive           = st_ff.boot_drive;
  assign mode_cfg             = st_ff.mode;
  assign opt_cfg              = st_ff.opt;
  assign drive_type           = st_ff.dtype;
  assign drv0_cfg             = st_ff.drv0;
  assign drv1_cfg             = st_ff.drv1;
  assign fdc_active           = st_ff.act;

  property p_fdc_gate;
    @(posedge clk_sys) disable iff (rst)
      !floppy_dma_gate |=> !fdc_irq.oe && !fdc_dack.oe && !fdc_drq_seen;
  endproperty
  a_fdc_gate: assert property (p_fdc_gate)
    else $error("Floppy pins driven with DMA gate low.");

  property p_fdc_off;
    @(posedge clk_sys) disable iff (rst)
      (!fdc_active || fdc_pwr_down) |=> !fdc_irq.oe && !fdc_dack.oe;
  endproperty
  a_fdc_off: assert property (p_fdc_off)
    else $error("Floppy pins driven while floppy is off.");

  property p_uart_gate;
    @(posedge clk_sys) disable iff (rst)
      !uart_irq_gate[1] |=> !uart_irq[1].oe;
  endproperty
  a_uart_gate: assert property (p_uart_gate)
    else $error("UART interrupt driven with its gate low.");

  property p_spp_irq;
    @(posedge clk_sys) disable iff (rst)
      !ecp_on && !port_irq_enable |=> !par_irq.oe;
  endproperty
  a_spp_irq: assert property (p_spp_irq)
    else $error("Parallel interrupt driven with enable low.");

  property p_ecp_irq;
    @(posedge clk_sys) disable iff (rst)
      ecp_on && dev_on[2] && ecr_mode == `FCG_ECR_TEST |=> par_irq.oe;
  endproperty
  a_ecp_irq: assert property (p_ecp_irq)
    else $error("Parallel interrupt not forced on in test mode.");

  property p_ecp_dma;
    @(posedge clk_sys) disable iff (rst)
      !ecp_dma_enable |=> !parallel_dma_request.oe;
  endproperty
  a_ecp_dma: assert property (p_ecp_dma)
    else $error("Parallel DMA request driven with enable low.");

  property p_base_bad;
    @(posedge clk_sys) disable iff (rst)
      !fdc_base_ok ##1 !fdc_base_ok |-> !fdc_irq.oe && !fdc_drq_seen;
  endproperty
  a_base_bad: assert property (p_base_bad)
    else $error("Floppy pins driven with a bad base address.");

  property p_hard_reset;
    @(posedge clk_sys) disable iff (rst)
      $fell(rst) |-> mode_cfg == `FCG_RST_MODE &&
                     drive_type == `FCG_RST_TYPE && !fdc_active;
  endproperty
  a_hard_reset: assert property (p_hard_reset)
    else $error("Configuration not at defaults after reset.");

  property p_mode_wr;
    @(posedge clk_sys) disable iff (rst)
      wr_done && paddr == `FCG_ADDR(`FCG_IDX_MODE)
      |=> mode_cfg == ($past(wbyte) & `FCG_MASK_MODE);
  endproperty
  a_mode_wr: assert property (p_mode_wr)
    else $error("Mode register did not take the written value.");

  property p_swap;
    @(posedge clk_sys) disable iff (rst)
      mode_cfg.swap |=> drv_sel_pp == $past(sel_rev);
  endproperty
  a_swap: assert property (p_swap)
    else $error("Drive selects not exchanged with swap set.");

  property p_open_drain;
    @(posedge clk_sys) disable iff (rst)
      !mode_cfg.push_pull && drv_sel_req[0] && !mode_cfg.swap
      |=> !drv_sel[0].oe;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("Open-drain select drove a high level.");

  property p_tristate;
    @(posedge clk_sys) disable iff (rst)
      mode_cfg.tristate |=> !drv_sel[0].oe && !drv_sel[1].oe &&
                            !mot[0].oe && !mot[1].oe;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("Floppy outputs driven while tri-stated.");

  property p_density;
    @(posedge clk_sys) disable iff (rst)
      opt_cfg.density == `FCG_DENS_LO |=> !dens_o;
  endproperty
  a_density: assert property (p_density)
    else $error("Density not forced low.");

  property p_boot;
    @(posedge clk_sys) disable iff (rst)
      opt_cfg.boot[1] |=> !boot_valid;
  endproperty
  a_boot: assert property (p_boot)
    else $error("Boot drive named with reserved code.");

  property p_rsvd_rd;
    @(posedge clk_sys) disable iff (rst)
      psel && !penable && paddr == `FCG_ADDR(`FCG_IDX_RSVD)
      |=> pready && prdata == 32'h0 && !pslverr;
  endproperty
  a_rsvd_rd: assert property (p_rsvd_rd)
    else $error("Reserved index did not read zero.");

  property p_drv_zero;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |-> (drv0_cfg & ~`FCG_MASK_DRV) == 8'h00 &&
               (drv1_cfg & ~`FCG_MASK_DRV) == 8'h00;
  endproperty
  a_drv_zero: assert property (p_drv_zero)
    else $error("Unused drive settings bits not zero.");

  property p_link;
    @(posedge clk_sys) disable iff (rst)
      wr_done && paddr == `FCG_ADDR(`FCG_IDX_CTRL) &&
      wbyte[`FCG_CTRL_PWR] |=> fdc_active;
  endproperty
  a_link: assert property (p_link)
    else $error("Power bit did not activate the device.");

endmodule

// *** dv/fcg_host_model.sv ***
// Host-side model that resolves the interrupt and DMA lines it sees.
`timescale 1ns/100ps
module fcg_host_model (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire fcg_pkg::fcg_pin_t [5:0] pins,
  output wire logic [5:0]              line
);
  logic [5:0] hold_ff;
  // A floated line flips each cycle so a stale level can never pass.
  for (genvar i = 0; i < 6; i++) begin : g_res
    assign line[i] = pins[i].oe ? pins[i].o : ~hold_ff[i];
  end
  always_ff @(posedge clk_sys) begin
    if (rst) hold_ff <= '0;
    else hold_ff <= line;
  end
endmodule

// *** dv/test_fdc_config_and_irq_dma_gating.sv ***
// Self-checking bench for the floppy configuration and gating block.
`timescale 1ns/100ps
module test_fdc_config_and_irq_dma_gating;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        dma_gate, base_ok, pwr_dn, irq_rq, dack_rq, drq_pin, drq_seen;
  logic [2:0]  dev_on, ecr_mode;
  logic [1:0]  ugate, ureq, dsel_rq, mot_rq, mid_pin, dsel_pp, mot_pp, mid;
  logic        ecp_on, pie, ecp_dma, pirq_rq, pdrq_rq, dens_rq, dens_o;
  logic        boot_valid, boot_drive, active;
  logic [5:0]  line;
  logic [7:0]  cfg_mode, cfg_opt, cfg_type, cfg_drv0, cfg_drv1;
  int          bad_count, checks_done;
  fcg_pkg::fcg_pin_t       fdc_irq, fdc_dack, par_irq, par_dma;
  fcg_pkg::fcg_pin_t [1:0] uart_irq, drv_sel, mot;

  fcg_core u_dut (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .floppy_dma_gate(dma_gate),
    .fdc_base_ok(base_ok), .fdc_pwr_down(pwr_dn), .fdc_irq_req(irq_rq),
    .fdc_dack_req(dack_rq), .fdc_drq_pin(drq_pin), .fdc_drq_seen(drq_seen),
    .dev_on(dev_on), .uart_irq_gate(ugate), .uart_irq_req(ureq),
    .ecp_on(ecp_on), .ecr_mode(ecr_mode), .port_irq_enable(pie),
    .ecp_dma_enable(ecp_dma), .par_irq_req(pirq_rq), .par_dreq_req(pdrq_rq),
    .drv_sel_req(dsel_rq), .mot_req(mot_rq), .dens_req(dens_rq),
    .media_id_pin(mid_pin), .fdc_irq(fdc_irq), .fdc_dack(fdc_dack),
    .uart_irq(uart_irq), .par_irq(par_irq), .parallel_dma_request(par_dma),
    .drv_sel(drv_sel), .mot(mot), .drv_sel_pp(dsel_pp), .mot_pp(mot_pp),
    .dens_o(dens_o), .media_id(mid), .boot_valid(boot_valid),
    .boot_drive(boot_drive), .mode_cfg(cfg_mode), .opt_cfg(cfg_opt),
    .drive_type(cfg_type), .drv0_cfg(cfg_drv0), .drv1_cfg(cfg_drv1),
    .fdc_active(active));

  fcg_host_model u_host (.clk_sys(clk_sys), .rst(rst),
    .pins({par_dma, par_irq, uart_irq, fdc_dack, fdc_irq}), .line(line));

  task automatic end_sim;
    if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(posedge clk_sys);
  endtask

  // The slave answer time is not assumed; a wait ends on pready or after 16 cycles.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      bad_count++;
      end_sim;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] x,
                       input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, {24'h0, x});
    chk(e, xe);
  endtask

  task automatic t_regs;
    logic [7:0] rv [6] = '{8'h0e, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
    logic [7:0] mk [6] = '{8'hdf, 8'hfc, 8'hff, 8'h00, 8'h5b, 8'h5b};
    chk({cfg_mode, cfg_opt, cfg_type, cfg_drv0}, 32'h0e00ff00);
    chk(cfg_drv1, 8'h00);
    for (int i = 0; i < 6; i++) begin
      rdchk(12'h3c0 + 12'(4 * i), rv[i], 1'b0);
      wr(12'h3c0 + 12'(4 * i), 8'hff);
      rdchk(12'h3c0 + 12'(4 * i), mk[i], 1'b0);
    end
    chk({cfg_mode, cfg_opt, cfg_type, cfg_drv0}, 32'hdffcff5b);
    chk(cfg_drv1, 8'h5b);
    rdchk(12'h100, 8'h00, 1'b1);
    rdchk(12'h3c1, 8'h00, 1'b1);
  endtask

  task automatic t_floppy;
    wr(12'h0c0, 8'h02);
    rdchk(12'h0c0, 8'h03, 1'b0);
    chk(active, 1'b1);
    {irq_rq, dack_rq, drq_pin} <= 3'b111;
    for (int c = 0; c < 5; c++) begin
      @(posedge clk_sys);
      dma_gate <= (c != 1);
      base_ok <= (c != 2);
      pwr_dn <= (c == 3);
      if (c == 4) wr(12'h0c0, 8'h00);
      settle(8);
      chk({fdc_irq, fdc_dack, drq_seen}, (c == 0) ? 5'h1f : 5'h00);
      if (c == 0) chk(line[1:0], 2'h3);
      if (c == 0) rdchk(12'h0c4, 8'h03, 1'b0);
    end
  endtask

  task automatic t_uart;
    logic e;
    ureq <= 2'b11;
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_sys);
      dev_on[1:0] <= c[2] ? {c[0], 1'b1} : {1'b1, c[0]};
      ugate <= c[2] ? {c[1], 1'b1} : {1'b1, c[1]};
      settle(3);
      e = (c[1:0] == 2'h3);
      chk(uart_irq, c[2] ? {e, e, 2'b11} : {2'b11, e, e});
    end
  endtask

  task automatic t_par;
    logic ir;
    logic dr;
    @(posedge clk_sys);
    {dev_on[2], pirq_rq, pdrq_rq, ecp_on} <= 4'hf;
    for (int m = 0; m < 10; m++) begin
      @(posedge clk_sys);
      ecr_mode <= m[2:0];
      ecp_dma <= m[0];
      pie <= (m == 5 || m == 9);
      ecp_on <= (m < 8);
      settle(3);
      ir = (m > 7) ? m[0] : (m == 2 || m == 3 || m == 5 || m == 6);
      dr = (m < 8) & m[0];
      chk({par_irq, par_dma}, {ir, ir, dr, dr});
    end
  endtask

  task automatic t_mode;
    {dsel_rq, mot_rq} <= 4'h6;
    wr(12'h3c0, 8'h50);
    settle(3);
    chk({drv_sel, mot, dsel_pp, mot_pp}, 12'hd79);
    wr(12'h3c0, 8'hd0);
    settle(3);
    chk({drv_sel[1].oe, drv_sel[0].oe, mot[1].oe, mot[0].oe,
         dsel_pp, mot_pp}, 8'h09);
    wr(12'h3c0, 8'h00);
    settle(3);
    chk({drv_sel, mot, dsel_pp, mot_pp}, 12'h696);
  endtask

  task automatic t_opt;
    logic [7:0] ov [3] = '{8'h60, 8'h80, 8'h10};
    logic [3:0] ex [3] = '{4'hf, 4'h4, 4'h2};
    for (int d = 0; d < 4; d++) begin
      @(posedge clk_sys);
      dens_rq <= (d != 2);
      wr(12'h3c4, 8'(d << 2));
      settle(3);
      chk(dens_o, d != 3);
    end
    for (int i = 0; i < 3; i++) begin
      wr(12'h3c4, ov[i]);
      settle(3);
      chk({mid, boot_valid, boot_drive & boot_valid}, ex[i]);
    end
  endtask

  // A hard reset in mid-run must bring every register back to default.
  task automatic t_reset;
    wr(12'h0c0, 8'h01);
    @(posedge clk_sys);
    chk(active, 1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    chk({cfg_mode, cfg_opt, cfg_type, cfg_drv0}, 32'h0e00ff00);
    chk({cfg_drv1, 7'h0, active}, 16'h0000);
    rdchk(12'h0c0, 8'h00, 1'b0);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {dma_gate, base_ok, pwr_dn, irq_rq, dack_rq, drq_pin} = '0;
    {dev_on, ecr_mode, ugate, ureq, dsel_rq, mot_rq} = '0;
    {ecp_on, pie, ecp_dma, pirq_rq, pdrq_rq, dens_rq} = '0;
    mid_pin = 2'b01;
    bad_count = 0;
    checks_done = 0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs;
    t_floppy;
    t_uart;
    t_par;
    t_mode;
    t_opt;
    t_reset;
    end_sim;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    end_sim;
  end
endmodule
